// [cdm_data_addressing.sv]
/*
  address decode and storage for the core data side: 256 bytes of internal
  ram, banked working registers, bit area, stack pointer, a few special
  registers, branch target arithmetic and external move steering.
  assumes the execution unit issues at most one operation per cycle.
*/
`timescale 1ns/100ps

// Overview of operation
// - relative offset signed, added to next address
// - direct 00-7F ram, 80-FF special registers
// - page target keeps upper bits of next
// - long call/jump loads full 16 bits
// - unused opcode behaves as no operation
// - flash from zero; top reserved, not used
// - store enable steers external writes to program
// - lower 128 bytes direct and indirect
// - above 7F: direct special, indirect upper ram
// - 00-1F four banks of eight registers
// - one bank active, status word bits 3,4
// - indirect pointer only registers 0 and 1
// - 20-2F bytes give 128 addressable bits
// - bit or byte chosen by operation kind
// - push increments pointer, then writes
// - reset loads stack pointer with 07
// - stack wraps within 256 byte ram
// - special bit access only at 0/8 nibbles
module cdm_data_addressing
  import cdm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic opValid,
  input wire cdm_op_e opKind,
  input wire logic [7:0] opAddr,
  input wire logic [7:0] opData,
  input wire logic [15:0] opNextPc,
  input wire logic [15:0] opTarget,
  output logic [7:0] rdData_r,
  output logic rdValid_r,
  output logic [15:0] pcTarget_r,
  output logic pcLoad_r,
  output logic noOperation_r,
  output logic pgmWrEn_r,
  output logic [15:0] pgmWrAddr_r,
  output logic [7:0] pgmWrData_r,
  output logic pgmReserved_r,
  output logic xdataWrEn_r,
  output logic [15:0] xdataWrAddr_r,
  output logic [7:0] xdataWrData_r,
  output logic [7:0] stackPointer_r
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] ramMem [256];
  logic [7:0] dataPointerLow_r;
  logic [7:0] dataPointerHigh_r;
  logic [7:0] programStoreControl_r;
  logic [7:0] programStatusWord_r;
  logic [7:0] accumulator_r;
  logic [7:0] multiplyHelper_r;

  logic [1:0] activeBank;
  logic [7:0] regAddr;
  logic [7:0] ptrAddr;
  logic [7:0] indAddr;
  logic [7:0] bitByteAddr;
  logic [7:0] bitByteVal;
  logic [7:0] bitByteNew;
  logic [7:0] sfrRdVal;
  logic [7:0] stackPointer_nxt;
  logic memWr;
  logic [7:0] memWrAddr;
  logic [7:0] memWrData;
  logic sfrWr;
  logic [7:0] sfrWrAddr;
  logic [7:0] sfrWrData;
  logic [7:0] rdData_nxt;
  logic rdValid_nxt;
  logic bitSfrOk;

  function automatic logic [7:0] sfrRead(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      STACK_POINTER_ADDR: v = stackPointer_r;
      DATA_POINTER_LOW_ADDR: v = dataPointerLow_r;
      DATA_POINTER_HIGH_ADDR: v = dataPointerHigh_r;
      PROGRAM_STORE_CONTROL_ADDR: v = programStoreControl_r;
      PROGRAM_STATUS_WORD_ADDR: v = programStatusWord_r;
      ACCUMULATOR_ADDR: v = accumulator_r;
      MULTIPLY_HELPER_ADDR: v = multiplyHelper_r;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    activeBank = {programStatusWord_r[BANK_SELECT_HIGH_POS],
                  programStatusWord_r[BANK_SELECT_LOW_POS]};
    regAddr = {3'b000, activeBank, opAddr[2:0]};
    ptrAddr = {3'b000, activeBank, 2'b00, opAddr[0]};
    indAddr = ramMem[ptrAddr];
    // bit area in ram below 80, special register base above
    if (opAddr[7]) begin
      bitByteAddr = {opAddr[7:3], 3'b000};
      bitByteVal = sfrRead(bitByteAddr);
    end else begin
      bitByteAddr = {BIT_AREA_HIGH_NIBBLE, opAddr[6:3]};
      bitByteVal = ramMem[bitByteAddr];
    end
    bitByteNew = bitByteVal;
    bitByteNew[opAddr[2:0]] = opData[0];
    bitSfrOk = (bitByteAddr[3:0] == 4'h0) || (bitByteAddr[3:0] == 4'h8);
    sfrRdVal = sfrRead(opAddr);
  end

  always_comb begin
    memWr = 1'b0;
    memWrAddr = 8'h00;
    memWrData = opData;
    sfrWr = 1'b0;
    sfrWrAddr = opAddr;
    sfrWrData = opData;
    rdData_nxt = 8'h00;
    rdValid_nxt = 1'b0;
    stackPointer_nxt = stackPointer_r;
    if (opValid) begin
      unique case (opKind)
        OP_DIRECT_RD: begin
          rdValid_nxt = 1'b1;
          rdData_nxt = opAddr[7] ? sfrRdVal : ramMem[opAddr];
        end
        OP_DIRECT_WR: begin
          memWr = !opAddr[7];
          memWrAddr = opAddr;
          sfrWr = opAddr[7];
        end
        OP_INDIRECT_RD: begin
          rdValid_nxt = 1'b1;
          rdData_nxt = ramMem[indAddr];
        end
        OP_INDIRECT_WR: begin
          memWr = 1'b1;
          memWrAddr = indAddr;
        end
        OP_REGISTER_RD: begin
          rdValid_nxt = 1'b1;
          rdData_nxt = ramMem[regAddr];
        end
        OP_REGISTER_WR: begin
          memWr = 1'b1;
          memWrAddr = regAddr;
        end
        OP_BIT_RD: begin
          rdValid_nxt = 1'b1;
          rdData_nxt = {7'h00, bitByteVal[opAddr[2:0]]};
        end
        OP_BIT_WR: begin
          memWr = !opAddr[7];
          memWrAddr = bitByteAddr;
          memWrData = bitByteNew;
          sfrWr = opAddr[7] && bitSfrOk;
          sfrWrAddr = bitByteAddr;
          sfrWrData = bitByteNew;
        end
        OP_PUSH: begin
          stackPointer_nxt = stackPointer_r + 8'h01;
          memWr = 1'b1;
          memWrAddr = stackPointer_nxt;
        end
        OP_POP: begin
          rdValid_nxt = 1'b1;
          rdData_nxt = ramMem[stackPointer_r];
          stackPointer_nxt = stackPointer_r - 8'h01;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal ram
  always_ff @(posedge clk) begin
    if (memWr) begin
      ramMem[memWrAddr] <= memWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special registers; unlisted addresses swallow writes
  always_ff @(posedge clk) begin
    if (srst) begin
      stackPointer_r <= STACK_POINTER_RST;
      dataPointerLow_r <= REG_RST;
      dataPointerHigh_r <= REG_RST;
      programStoreControl_r <= REG_RST;
      programStatusWord_r <= REG_RST;
      accumulator_r <= REG_RST;
      multiplyHelper_r <= REG_RST;
    end else begin
      stackPointer_r <= stackPointer_nxt;
      if (sfrWr) begin
        unique case (sfrWrAddr)
          STACK_POINTER_ADDR: stackPointer_r <= sfrWrData;
          DATA_POINTER_LOW_ADDR: dataPointerLow_r <= sfrWrData;
          DATA_POINTER_HIGH_ADDR: dataPointerHigh_r <= sfrWrData;
          PROGRAM_STORE_CONTROL_ADDR: programStoreControl_r <= sfrWrData;
          PROGRAM_STATUS_WORD_ADDR: programStatusWord_r[7:1] <= sfrWrData[7:1];
          ACCUMULATOR_ADDR: accumulator_r <= sfrWrData;
          MULTIPLY_HELPER_ADDR: multiplyHelper_r <= sfrWrData;
          default: begin
          end
        endcase
      end
      // parity of the accumulator, read only
      programStatusWord_r[PARITY_POS] <= ^((sfrWr && sfrWrAddr == ACCUMULATOR_ADDR) ?
                                           sfrWrData : accumulator_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answers
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // branch targets and opcode decode
  always_ff @(posedge clk) begin
    if (srst) begin
      pcTarget_r <= 16'h0000;
      pcLoad_r <= 1'b0;
      noOperation_r <= 1'b0;
    end else begin
      pcLoad_r <= 1'b0;
      noOperation_r <= 1'b0;
      if (opValid) begin
        unique case (opKind)
          OP_BRANCH_REL: begin
            pcTarget_r <= opNextPc + {{8{opTarget[7]}}, opTarget[7:0]};
            pcLoad_r <= 1'b1;
          end
          OP_BRANCH_PAGE: begin
            pcTarget_r <= {opNextPc[15:11], opTarget[10:0]};
            pcLoad_r <= 1'b1;
          end
          OP_BRANCH_LONG: begin
            pcTarget_r <= opTarget;
            pcLoad_r <= 1'b1;
          end
          OP_DECODE: begin
            noOperation_r <= (opAddr == NO_OPERATION_CODE) ||
                             (opAddr == UNUSED_OPCODE);
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external data move steering
  always_ff @(posedge clk) begin
    if (srst) begin
      pgmWrEn_r <= 1'b0;
      pgmWrAddr_r <= 16'h0000;
      pgmWrData_r <= 8'h00;
      pgmReserved_r <= 1'b0;
      xdataWrEn_r <= 1'b0;
      xdataWrAddr_r <= 16'h0000;
      xdataWrData_r <= 8'h00;
    end else begin
      pgmWrEn_r <= 1'b0;
      pgmReserved_r <= 1'b0;
      xdataWrEn_r <= 1'b0;
      if (opValid && opKind == OP_EXTERNAL_WR) begin
        if (programStoreControl_r[STORE_WRITE_ENABLE_POS]) begin
          // reserved top of flash is never written
          pgmWrEn_r <= (opTarget <= PROGRAM_LAST_USABLE);
          pgmReserved_r <= (opTarget > PROGRAM_LAST_USABLE);
          pgmWrAddr_r <= opTarget;
          pgmWrData_r <= opData;
        end else begin
          xdataWrEn_r <= 1'b1;
          xdataWrAddr_r <= opTarget;
          xdataWrData_r <= opData;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence pushIssued;
    opValid && opKind == OP_PUSH;
  endsequence

  sequence popIssued;
    opValid && opKind == OP_POP;
  endsequence

  stack_reset_a: assert property (disable iff (1'b0)
      srst |=> stackPointer_r == STACK_POINTER_RST)
    else $error("stack pointer not at reset value after reset");
  push_order_a: assert property (pushIssued |=>
      stackPointer_r == $past(stackPointer_r) + 8'h01 &&
      ramMem[stackPointer_r] == $past(opData))
    else $error("push did not increment then write");
  pop_order_a: assert property (popIssued |=>
      stackPointer_r == $past(stackPointer_r) - 8'h01 && rdValid_r)
    else $error("pop did not read then decrement");
  rel_branch_a: assert property (opValid && opKind == OP_BRANCH_REL |=>
      pcLoad_r &&
      pcTarget_r == $past(opNextPc) + {{8{$past(opTarget[7])}}, $past(opTarget[7:0])})
    else $error("relative target wrong");
  page_branch_a: assert property (opValid && opKind == OP_BRANCH_PAGE |=>
      pcLoad_r && pcTarget_r[15:11] == $past(opNextPc[15:11]) &&
      pcTarget_r[10:0] == $past(opTarget[10:0]))
    else $error("page target wrong or outside its page");
  long_branch_a: assert property (opValid && opKind == OP_BRANCH_LONG |=>
      pcLoad_r && pcTarget_r == $past(opTarget))
    else $error("long target not loaded");
  unused_opcode_a: assert property (
      opValid && opKind == OP_DECODE && opAddr == UNUSED_OPCODE |=> noOperation_r)
    else $error("unused opcode not treated as no operation");
  store_steer_a: assert property (opValid && opKind == OP_EXTERNAL_WR |=>
      xdataWrEn_r == !$past(programStoreControl_r[STORE_WRITE_ENABLE_POS]))
    else $error("external write steered wrongly");
  reserved_flash_a: assert property (pgmWrEn_r |-> pgmWrAddr_r <= PROGRAM_LAST_USABLE)
    else $error("write into reserved flash");
  bank_write_a: assert property (opValid && opKind == OP_REGISTER_WR |=>
      ramMem[{3'b000, $past(activeBank), $past(opAddr[2:0])}] == $past(opData))
    else $error("banked register write missed");
  direct_split_a: assert property (opValid && opKind == OP_DIRECT_WR && !opAddr[7] |=>
      ramMem[$past(opAddr)] == $past(opData))
    else $error("direct ram write missed");
endmodule

// [cdm_exec_model.sv]
/*
  execution unit model: issues one operation per call, driven at the
  falling edge. assumes the addressing block samples on the rising edge.
*/
`timescale 1ns/100ps
module cdm_exec_model
  import cdm_pkg::*;
(
  input wire logic clk,
  output logic opValid,
  output cdm_op_e opKind,
  output logic [7:0] opAddr,
  output logic [7:0] opData,
  output logic [15:0] opNextPc,
  output logic [15:0] opTarget
);
  initial begin
    opValid = 1'b0;
    opKind = OP_DIRECT_RD;
    opAddr = 8'h00;
    opData = 8'h00;
    opNextPc = 16'h0000;
    opTarget = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // gap idle cycles first, so issue can be prompt or slow
  // callers pass listed special addresses only
  task automatic issue(input cdm_op_e k, input logic [7:0] a, input logic [7:0] d,
                       input logic [15:0] pc, input logic [15:0] t, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    opValid = 1'b1;
    opKind = k;
    opAddr = a;
    opData = d;
    opNextPc = pc;
    opTarget = t;
    @(negedge clk);
    opValid = 1'b0;
    // released address, data and target lines no longer show the old value
    opAddr = ~a;
    opData = ~d;
    opTarget = ~t;
  endtask
endmodule

// [cdm_pkg.sv]
/*
  constants, register offsets and operation kinds for the core data memory
  addressing block. assumes one 100 MHz clock and a synchronous reset.
*/
package cdm_pkg;
  // special register offsets
  localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0] DATA_POINTER_LOW_ADDR = 8'h82;
  localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
  localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8f;
  localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
  localparam logic [7:0] ACCUMULATOR_ADDR = 8'he0;
  localparam logic [7:0] MULTIPLY_HELPER_ADDR = 8'hf0;
  // reset values
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] REG_RST = 8'h00;
  // field positions
  localparam int BANK_SELECT_LOW_POS = 3;
  localparam int BANK_SELECT_HIGH_POS = 4;
  localparam int PARITY_POS = 0;
  localparam int STORE_WRITE_ENABLE_POS = 0;
  // data space layout
  localparam logic [7:0] SPECIAL_SPACE_BASE = 8'h80;
  localparam logic [3:0] BIT_AREA_HIGH_NIBBLE = 4'h2;
  // program space
  localparam logic [15:0] PROGRAM_LAST_USABLE = 16'h3dff;
  localparam logic [15:0] PROGRAM_FLASH_LAST = 16'h3fff;
  // opcodes
  localparam logic [7:0] NO_OPERATION_CODE = 8'h00;
  localparam logic [7:0] UNUSED_OPCODE = 8'ha5;

  typedef enum logic [3:0] {
    OP_DIRECT_RD,
    OP_DIRECT_WR,
    OP_INDIRECT_RD,
    OP_INDIRECT_WR,
    OP_REGISTER_RD,
    OP_REGISTER_WR,
    OP_BIT_RD,
    OP_BIT_WR,
    OP_PUSH,
    OP_POP,
    OP_EXTERNAL_WR,
    OP_BRANCH_REL,
    OP_BRANCH_PAGE,
    OP_BRANCH_LONG,
    OP_DECODE
  } cdm_op_e;
endpackage

// [core_data_memory_addressing_tb.sv]
/*
  self-checking bench for the data memory addressing block.
  assumes answers are registered at the taking edge and read at the next falling edge.
*/
`timescale 1ns/100ps
module core_data_memory_addressing_tb;
  import cdm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic opValid, rdValid, pcLoad, noOp, pgmEn, pgmRes, xEn;
  cdm_op_e opKind;
  logic [7:0] opAddr, opData, rdData, sp, pgmData, xData, a, d, off;
  logic [15:0] opNextPc, opTarget, pcTarget, pgmAddr, xAddr, pc, t;
  int fails = 0;
  int compares = 0;
  int seed = 12786;

  always #5 clk = ~clk;

  cdm_exec_model cdm_exec_model_inst (.clk(clk), .opValid(opValid), .opKind(opKind),
    .opAddr(opAddr), .opData(opData), .opNextPc(opNextPc), .opTarget(opTarget));

  cdm_data_addressing cdm_data_addressing_inst (.clk(clk), .srst(srst), .opValid(opValid),
    .opKind(opKind), .opAddr(opAddr), .opData(opData), .opNextPc(opNextPc),
    .opTarget(opTarget), .rdData_r(rdData), .rdValid_r(rdValid), .pcTarget_r(pcTarget),
    .pcLoad_r(pcLoad), .noOperation_r(noOp), .pgmWrEn_r(pgmEn), .pgmWrAddr_r(pgmAddr),
    .pgmWrData_r(pgmData), .pgmReserved_r(pgmRes), .xdataWrEn_r(xEn),
    .xdataWrAddr_r(xAddr), .xdataWrData_r(xData), .stackPointer_r(sp));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkFlag(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask

  // expected branch targets, worked out from the addressing rules
  function automatic logic [15:0] relTarget(input logic [15:0] p, input logic [7:0] o);
    return p + {{8{o[7]}}, o};
  endfunction

  function automatic logic [15:0] pageTarget(input logic [15:0] p, input logic [15:0] g);
    return {p[15:11], g[10:0]};
  endfunction

  task automatic op(input cdm_op_e k, input logic [7:0] ad, input logic [7:0] dt,
                    input logic [15:0] p = 16'h0000, input logic [15:0] tg = 16'h0000);
    cdm_exec_model_inst.issue(k, ad, dt, p, tg, int'($unsigned($random(seed)) % 3));
  endtask

  task automatic rdk(input cdm_op_e k, input logic [7:0] ad, input logic [7:0] e,
                     input string n);
    op(k, ad, 8'h00);
    chkFlag("read valid", 1'b1, rdValid);
    chk(n, {8'h00, e}, {8'h00, rdData});
  endtask

  task automatic br(input cdm_op_e k, input logic [15:0] e);
    op(k, 8'h00, 8'h00, pc, t);
    chkFlag("pc load", 1'b1, pcLoad);
    chk("pc target", e, pcTarget);
  endtask

  task automatic ext(input logic [15:0] ad, input logic p, input logic x, input logic r);
    op(OP_EXTERNAL_WR, 8'h00, d, 16'h0000, ad);
    chkFlag("program write", p, pgmEn);
    chkFlag("external write", x, xEn);
    chkFlag("program refused", r, pgmRes);
    if (p) chk("program address", ad, pgmAddr);
    if (x) chk("external address", ad, xAddr);
  endtask

  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk("stack pointer", 16'h0007, {8'h00, sp});
    for (int i = 0; i < 4; i++) begin
      a = 8'h30 + 8'($unsigned($random(seed)) % 80);
      d = 8'($random(seed));
      op(OP_DIRECT_WR, a, d);
      rdk(OP_DIRECT_RD, a, d, "direct ram");
      op(OP_DIRECT_WR, 8'h00, a);
      rdk(OP_INDIRECT_RD, 8'h00, d, "indirect ram");
    end
    op(OP_DIRECT_WR, 8'h01, 8'h81);
    op(OP_INDIRECT_WR, 8'h01, 8'h5a);
    rdk(OP_INDIRECT_RD, 8'h01, 8'h5a, "upper ram");
    rdk(OP_DIRECT_RD, 8'h81, 8'h07, "special space");
    for (int n = 0; n < 4; n++) begin
      op(OP_DIRECT_WR, 8'hd0, 8'(n * 8));
      op(OP_REGISTER_WR, 8'(n + 2), 8'(8'ha0 + n));
      rdk(OP_DIRECT_RD, 8'(n * 9 + 2), 8'(8'ha0 + n), "bank base");
      rdk(OP_REGISTER_RD, 8'(n + 2), 8'(8'ha0 + n), "bank register");
    end
    op(OP_DIRECT_WR, 8'hd0, 8'h00);
    op(OP_DIRECT_WR, 8'h22, 8'h00);
    op(OP_BIT_WR, 8'h13, 8'h01);
    rdk(OP_DIRECT_RD, 8'h22, 8'h08, "bit area byte");
    op(OP_BIT_RD, 8'h13, 8'h00);
    chkFlag("bit read", 1'b1, rdData[0]);
    op(OP_BIT_WR, 8'he3, 8'h01);
    rdk(OP_DIRECT_RD, 8'he0, 8'h08, "special bit");
    d = 8'($random(seed));
    op(OP_PUSH, 8'h00, d);
    chk("push pointer", 16'h0008, {8'h00, sp});
    rdk(OP_DIRECT_RD, 8'h08, d, "push data");
    rdk(OP_POP, 8'h00, d, "pop data");
    chk("pop pointer", 16'h0007, {8'h00, sp});
    op(OP_DIRECT_WR, 8'h81, 8'hff);
    op(OP_PUSH, 8'h00, 8'h3c);
    chk("wrap pointer", 16'h0000, {8'h00, sp});
    rdk(OP_DIRECT_RD, 8'h00, 8'h3c, "wrap data");
    for (int i = 0; i < 4; i++) begin
      pc = 16'($random(seed));
      t = 16'($random(seed));
      off = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : t[7:0];
      t[7:0] = off;
      br(OP_BRANCH_REL, relTarget(pc, off));
      br(OP_BRANCH_PAGE, pageTarget(pc, t));
      br(OP_BRANCH_LONG, t);
    end
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'ha5 : 8'h01;
      op(OP_DECODE, a, 8'h00);
      chkFlag("no operation", i != 2, noOp);
    end
    d = 8'($random(seed));
    ext(16'h3dff, 1'b0, 1'b1, 1'b0);
    chk("external data", {8'h00, d}, {8'h00, xData});
    op(OP_DIRECT_WR, 8'h8f, 8'h01);
    ext(16'h3dff, 1'b1, 1'b0, 1'b0);
    chk("program data", {8'h00, d}, {8'h00, pgmData});
    ext(16'h3e00, 1'b0, 1'b0, 1'b1);
    ext(16'h0000, 1'b1, 1'b0, 1'b0);
    // reset in mid-run: pointer and store enable return to reset state
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("reset pointer", 16'h0007, {8'h00, sp});
    ext(16'h0100, 1'b0, 1'b1, 1'b0);
    final_report();
  end
endmodule
